// ==== rtc_pkg.sv ====
// constants and types for the bcd clock/calendar register block
package rtc_pkg;
    // ****************************************************
    // register map (indices inside the special group)
    // ****************************************************
    localparam logic [2:0] IDX_VIEW = 3'h0;
    localparam logic [2:0] IDX_MIN_SEC = 3'h1;
    localparam logic [2:0] IDX_DAY_HOUR = 3'h2;
    localparam logic [2:0] IDX_YEAR_MONTH = 3'h3;
    localparam logic [2:0] IDX_WEEKDAY = 3'h4;
    localparam logic [2:0] IDX_COMMAND = 3'h5;
    // ****************************************************
    // command codes
    // ****************************************************
    localparam logic [15:0] CMD_SET = 16'h8000;
    localparam logic [15:0] CMD_IDLE = 16'h0000;
    localparam logic [15:0] CMD_COMP30 = 16'h4000;
    // ****************************************************
    // bcd limits
    // ****************************************************
    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_ONE = 8'h01;
    localparam logic [7:0] BCD_SEC_MAX = 8'h59;
    localparam logic [7:0] BCD_HOUR_MAX = 8'h23;
    localparam logic [7:0] BCD_MONTH_MAX = 8'h12;
    localparam logic [7:0] BCD_YEAR_MAX = 8'h99;
    localparam logic [7:0] BCD_WDAY_MAX = 8'h06;
    localparam logic [7:0] BCD_THIRTY = 8'h30;
    localparam logic [7:0] BCD_FEB = 8'h02;
    localparam logic [7:0] BCD_APR = 8'h04;
    localparam logic [7:0] BCD_JUN = 8'h06;
    localparam logic [7:0] BCD_SEP = 8'h09;
    localparam logic [7:0] BCD_NOV = 8'h11;
    localparam logic [7:0] DAYS_31 = 8'h31;
    localparam logic [7:0] DAYS_30 = 8'h30;
    localparam logic [7:0] DAYS_29 = 8'h29;
    localparam logic [7:0] DAYS_28 = 8'h28;
    // ****************************************************
    // timing
    // ****************************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_SECONDS = 1;
    localparam int TICK_CYCLES = CLK_HZ * TICK_SECONDS;
    // ****************************************************
    // types
    // ****************************************************
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
        logic [7:0] weekday;
    } time_type;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] index;
        logic [15:0] data;
    } reg_req_type;
    typedef enum logic {
        MODE_CLOCK_ONLY,
        MODE_CLOCK_MEMORY
    } mode_type;
endpackage

// ==== bcd_digit_counter.sv ====
// one bcd two-digit counter with limit and restart value
`timescale 1ns/1ps
module bcd_digit_counter (
    // value in
    input wire logic [7:0] value,
    input wire logic [7:0] low,
    input wire logic [7:0] high,
    // result
    output logic [7:0] incremented,
    output logic wrapped
);
    always_comb begin
        wrapped = (value >= high);
        if (wrapped) begin
            incremented = low;
        end else if (value[3:0] == 4'h9) begin
            incremented = {value[7:4] + 4'h1, 4'h0};
        end else begin
            incremented = {value[7:4], value[3:0] + 4'h1};
        end
    end
endmodule

// ==== bcd_clock_calendar_registers.sv ====
// clock/calendar special register block with bcd time keeping
`timescale 1ns/1ps
module bcd_clock_calendar_registers #(
    parameter int TICK_COUNT = rtc_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire rtc_pkg::reg_req_type req,
    output logic [15:0] readData,
    output logic readValid,
    // pins
    input wire logic batteryPresent,
    input wire logic modeSwitch,
    // status
    output logic masterMemoryEnable,
    output logic timeValid,
    output logic secondPulse
);
    import rtc_pkg::*;
    // ****************************************************
    // parameter check
    // ****************************************************
    // the tick compare needs at least two counter states
    if (TICK_COUNT < 2) begin : g_badTick
        $error("tick count too small");
    end
    // ****************************************************
    // pin synchronisers
    // ****************************************************
    // pins are asynchronous: two stages before any use
    logic [1:0] batSync;
    logic [1:0] modeSync;
    logic [1:0] next_batSync;
    logic [1:0] next_modeSync;
    always_comb begin
        next_batSync = {batSync[0], batteryPresent};
        next_modeSync = {modeSync[0], modeSwitch};
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            batSync <= 2'h0;
            modeSync <= 2'h0;
        end else begin
            batSync <= next_batSync;
            modeSync <= next_modeSync;
        end
    end
    logic batOk;
    mode_type mode;
    assign batOk = batSync[1];
    assign mode = modeSync[1] ? MODE_CLOCK_MEMORY : MODE_CLOCK_ONLY;
    // ****************************************************
    // second tick
    // ****************************************************
    logic [31:0] tickCnt;
    logic [31:0] next_tickCnt;
    logic tick;
    always_comb begin
        tick = 1'b0;
        next_tickCnt = tickCnt;
        if (!batOk) begin
            // held clear so the first second after fitting is full
            next_tickCnt = 32'h0;
        end else if (tickCnt == 32'(TICK_COUNT - 1)) begin
            next_tickCnt = 32'h0;
            tick = 1'b1;
        end else begin
            next_tickCnt = tickCnt + 32'h1;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tickCnt <= 32'h0;
        end else begin
            tickCnt <= next_tickCnt;
        end
    end
    // ****************************************************
    // calendar carry chain
    // ****************************************************
    time_type now;
    time_type staged;
    time_type next_now;
    time_type next_staged;
    logic [7:0] incSec, incMin, incHour, incDay, incMon, incYear, incWday;
    logic wrapSec, wrapMin, wrapHour, wrapDay, wrapMon, wrapYear, wrapWday;
    logic [7:0] monthDays;
    logic leap;
    bcd_digit_counter secCnt (.value(now.second), .low(BCD_ZERO),
        .high(BCD_SEC_MAX), .incremented(incSec), .wrapped(wrapSec));
    bcd_digit_counter minCnt (.value(now.minute), .low(BCD_ZERO),
        .high(BCD_SEC_MAX), .incremented(incMin), .wrapped(wrapMin));
    bcd_digit_counter hourCnt (.value(now.hour), .low(BCD_ZERO),
        .high(BCD_HOUR_MAX), .incremented(incHour), .wrapped(wrapHour));
    bcd_digit_counter dayCnt (.value(now.day), .low(BCD_ONE),
        .high(monthDays), .incremented(incDay), .wrapped(wrapDay));
    bcd_digit_counter monCnt (.value(now.month), .low(BCD_ONE),
        .high(BCD_MONTH_MAX), .incremented(incMon), .wrapped(wrapMon));
    bcd_digit_counter yearCnt (.value(now.year), .low(BCD_ZERO),
        .high(BCD_YEAR_MAX), .incremented(incYear), .wrapped(wrapYear));
    bcd_digit_counter wdayCnt (.value(now.weekday), .low(BCD_ZERO),
        .high(BCD_WDAY_MAX), .incremented(incWday), .wrapped(wrapWday));
    // leap year in bcd: tens even and units 0,4,8, or tens odd and 2,6
    always_comb begin
        leap = now.year[4] ? (now.year[3:0] == 4'h2 || now.year[3:0] == 4'h6)
            : (now.year[3:0] == 4'h0 || now.year[3:0] == 4'h4
            || now.year[3:0] == 4'h8);
        if (now.month == BCD_FEB) begin
            monthDays = leap ? DAYS_29 : DAYS_28;
        end else if (now.month == BCD_APR || now.month == BCD_JUN
            || now.month == BCD_SEP || now.month == BCD_NOV) begin
            monthDays = DAYS_30;
        end else begin
            monthDays = DAYS_31;
        end
    end
    // ****************************************************
    // register writes, commit and compensation
    // ****************************************************
    logic valid;
    logic next_valid;
    logic cmdSet;
    logic cmdComp;
    logic bumpMin;
    always_comb begin
        next_now = now;
        next_staged = staged;
        next_valid = valid;
        cmdSet = req.wr && req.index == IDX_COMMAND && req.data == CMD_SET;
        cmdComp = req.wr && req.index == IDX_COMMAND
            && req.data == CMD_COMP30;
        if (req.wr) begin
            case (req.index)
                IDX_MIN_SEC: begin
                    next_staged.minute = req.data[15:8];
                    next_staged.second = req.data[7:0];
                end
                IDX_DAY_HOUR: begin
                    next_staged.day = req.data[15:8];
                    next_staged.hour = req.data[7:0];
                end
                IDX_YEAR_MONTH: begin
                    next_staged.year = req.data[15:8];
                    next_staged.month = req.data[7:0];
                end
                IDX_WEEKDAY: begin
                    next_staged.weekday = req.data[7:0];
                end
                default: begin
                end
            endcase
        end
        bumpMin = 1'b0;
        // commit wins over compensation and the tick in one cycle
        if (cmdSet) begin
            next_now = staged;
            next_valid = 1'b1;
        end else if (cmdComp && batOk) begin
            // round seconds to the nearest minute
            next_now.second = BCD_ZERO;
            bumpMin = (now.second >= BCD_THIRTY);
        end else if (tick) begin
            next_now.second = incSec;
            bumpMin = wrapSec;
        end
        // shared minute carry, so a rounded 23:59 rolls the date too
        if (bumpMin) begin
            next_now.minute = incMin;
            if (wrapMin) begin
                next_now.hour = incHour;
                if (wrapHour) begin
                    next_now.day = incDay;
                    next_now.weekday = incWday;
                    if (wrapDay) begin
                        next_now.month = incMon;
                        if (wrapMon) begin
                            next_now.year = incYear;
                        end
                    end
                end
            end
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            now <= '0;
            staged <= '0;
            valid <= 1'b0;
        end else begin
            now <= next_now;
            staged <= next_staged;
            valid <= next_valid;
        end
    end
    // ****************************************************
    // read path and status outputs
    // ****************************************************
    logic [15:0] viewWord;
    logic [15:0] next_readData;
    logic next_readValid;
    logic next_masterMemoryEnable;
    logic next_secondPulse;
    always_comb begin
        case (req.index)
            IDX_VIEW: viewWord = {now.hour, now.minute};
            IDX_MIN_SEC: viewWord = {now.minute, now.second};
            IDX_DAY_HOUR: viewWord = {now.day, now.hour};
            IDX_YEAR_MONTH: viewWord = {now.year, now.month};
            IDX_WEEKDAY: viewWord = {BCD_ZERO, now.weekday};
            default: viewWord = CMD_IDLE;
        endcase
        // an idle port reads zero so no stale time is left standing
        next_readData = req.rd ? viewWord : CMD_IDLE;
        next_readValid = req.rd;
        next_masterMemoryEnable = (mode == MODE_CLOCK_MEMORY);
        next_secondPulse = tick;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            readData <= 16'h0000;
            readValid <= 1'b0;
            masterMemoryEnable <= 1'b0;
            timeValid <= 1'b0;
            secondPulse <= 1'b0;
        end else begin
            readData <= next_readData;
            readValid <= next_readValid;
            masterMemoryEnable <= next_masterMemoryEnable;
            timeValid <= next_valid;
            secondPulse <= next_secondPulse;
        end
    end
    // ****************************************************
    // assertions
    // ****************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    view_layout_a: assert property (req.rd && req.index == IDX_VIEW
        |=> readData == {$past(now.hour), $past(now.minute)})
        else $error("view register layout wrong");
    read_group_a: assert property (req.rd && req.index == IDX_YEAR_MONTH
        |=> readValid && readData == {$past(now.year), $past(now.month)})
        else $error("year month read wrong");
    commit_load_a: assert property (cmdSet |=> now == $past(staged))
        else $error("commit did not load staged time");
    no_battery_a: assert property (!batOk && !cmdSet && !cmdComp
        |=> $stable(now)) else $error("time ran without battery");
    comp_second_a: assert property (cmdComp && batOk && !cmdSet
        |=> now.second == BCD_ZERO) else $error("compensation failed");
    hour_range_a: assert property (valid && now.hour <= BCD_HOUR_MAX
        && !cmdSet |=> now.hour <= BCD_HOUR_MAX)
        else $error("hour out of 24-hour range");
    weekday_wrap_a: assert property (tick && wrapSec && wrapMin
        && wrapHour && !cmdSet && !cmdComp && now.weekday == BCD_WDAY_MAX
        |=> now.weekday == BCD_ZERO) else $error("weekday wrap wrong");
    not_valid_a: assert property (!valid && !cmdSet |=> !valid)
        else $error("time valid without commit");
    mode_map_a: assert property (modeSync[1] |=> masterMemoryEnable)
        else $error("mode switch not reflected");
    clock_only_a: assert property (!modeSync[1]
        |=> !masterMemoryEnable) else $error("clock only mode lost");
    no_pulse_a: assert property (!batOk |=> !secondPulse)
        else $error("second counted without battery");
    ro_view_a: assert property (req.wr && req.index == IDX_VIEW
        |=> $stable(staged)) else $error("view register took a write");
    idle_port_a: assert property (!req.rd |=> !readValid
        && readData == CMD_IDLE) else $error("idle read port not quiet");
    comp_keep_a: assert property (cmdComp && batOk && !cmdSet
        && now.second < BCD_THIRTY |=> $stable(now.minute))
        else $error("compensation moved the minute");
    comp_round_a: assert property (cmdComp && batOk && !cmdSet
        && now.second >= BCD_THIRTY |=> now.minute != $past(now.minute))
        else $error("compensation did not round up");
    leap_day_a: assert property (tick && wrapSec && wrapMin && wrapHour
        && !cmdSet && !cmdComp && now.month == BCD_FEB
        && now.day == DAYS_28 && leap |=> now.day == DAYS_29)
        else $error("leap day skipped");
    pulse_width_a: assert property (secondPulse |=> !secondPulse)
        else $error("second pulse too long");
    valid_stays_a: assert property (valid |=> valid)
        else $error("time valid dropped");
    set_valid_a: assert property (cmdSet |=> timeValid)
        else $error("commit did not mark time valid");
    weekday_range_a: assert property (valid && !cmdSet
        && now.weekday <= BCD_WDAY_MAX |=> now.weekday <= BCD_WDAY_MAX)
        else $error("weekday out of range");
    minute_range_a: assert property (valid && !cmdSet
        && now.minute <= BCD_SEC_MAX |=> now.minute <= BCD_SEC_MAX)
        else $error("minute out of range");
    day_range_a: assert property (valid && !cmdSet && now.day >= BCD_ONE
        && now.day <= DAYS_31 |=> now.day >= BCD_ONE && now.day <= DAYS_31)
        else $error("day out of range");
    month_range_a: assert property (valid && !cmdSet
        && now.month >= BCD_ONE && now.month <= BCD_MONTH_MAX
        |=> now.month >= BCD_ONE && now.month <= BCD_MONTH_MAX)
        else $error("month out of range");
    // ****************************************************
    // cover points
    // ****************************************************
    cover_set_c: cover property (cmdSet ##1 timeValid);
    cover_comp_c: cover property (cmdComp && now.second >= BCD_THIRTY);
    cover_day_c: cover property (tick && wrapSec && wrapMin && wrapHour);
    cover_leap_c: cover property (tick && leap && now.month == BCD_FEB
        && now.day == DAYS_28 && wrapHour);
    cover_mode_c: cover property (modeSync[1] ##1 masterMemoryEnable);
endmodule

// ==== ctrl_program_model.sv ====
// controller program model driving the clock register port
`timescale 1ns/1ps
module ctrl_program_model (
    // clock
    input wire logic clk,
    // register port
    output rtc_pkg::reg_req_type req,
    input wire logic [15:0] readData,
    input wire logic readValid
);
    import rtc_pkg::*;

    initial begin
        req = '0;
    end

    // ****************************************************
    // register access
    // ****************************************************
    // one-cycle strobe; released data shows its inverse
    task automatic wr(input logic [2:0] idx, input logic [15:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, index: idx, data: d};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, index: idx, data: ~d};
    endtask

    task automatic rd(input logic [2:0] idx, output logic [15:0] d,
                      output logic v);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, index: idx, data: ~req.data};
        @(posedge clk);
        req.rd <= 1'b0;
        @(negedge clk);
        v = readValid;
        d = readData;
    endtask

    // ****************************************************
    // clock setting sequence
    // ****************************************************
    task automatic setClock(input logic [15:0] ms, input logic [15:0] dh,
                            input logic [15:0] ym, input logic [15:0] wd);
        wr(IDX_MIN_SEC, ms);
        wr(IDX_DAY_HOUR, dh);
        wr(IDX_YEAR_MONTH, ym);
        wr(IDX_WEEKDAY, wd);
        wr(IDX_COMMAND, CMD_SET);
        wr(IDX_COMMAND, CMD_IDLE);
    endtask
endmodule

// ==== bcd_clock_calendar_registers_test.sv ====
// self-checking bench for the clock/calendar register block
`timescale 1ns/1ps
module bcd_clock_calendar_registers_test;
    import rtc_pkg::*;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    reg_req_type req;
    logic [15:0] readData;
    logic readValid;
    logic batteryPresent = 1'b0;
    logic modeSwitch = 1'b0;
    logic masterMemoryEnable;
    logic timeValid;
    logic secondPulse;
    int n_fail = 0;
    int comparisons = 0;

    always #12.5 clk = ~clk;

    bcd_clock_calendar_registers #(.TICK_COUNT(10)) i_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .req(req),
        .readData(readData),
        .readValid(readValid),
        .batteryPresent(batteryPresent),
        .modeSwitch(modeSwitch),
        .masterMemoryEnable(masterMemoryEnable),
        .timeValid(timeValid),
        .secondPulse(secondPulse)
    );

    ctrl_program_model i_ctrl (
        .clk(clk),
        .req(req),
        .readData(readData),
        .readValid(readValid)
    );

    // ****************************************************
    // checking and closing
    // ****************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (n_fail == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic expectReg(input logic [2:0] idx, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        i_ctrl.rd(idx, d, v);
        check({15'h0000, v}, 16'h0001);
        check(d, exp);
    endtask

    // ****************************************************
    // scenarios
    // ****************************************************
    task automatic testResetState();
        @(negedge clk);
        check({15'h0000, timeValid}, 16'h0000);
        expectReg(IDX_VIEW, 16'h0000);
    endtask

    task automatic testSetAndHold();
        i_ctrl.setClock(16'h0000, 16'h0512, 16'h2407, 16'h0003);
        i_ctrl.wr(IDX_VIEW, 16'h0945);
        check({15'h0000, timeValid}, 16'h0001);
        expectReg(IDX_VIEW, 16'h1200);
        expectReg(IDX_DAY_HOUR, 16'h0512);
        expectReg(IDX_YEAR_MONTH, 16'h2407);
        repeat (40) @(posedge clk);
        expectReg(IDX_MIN_SEC, 16'h0000);
    endtask

    task automatic testRollover(input logic [15:0] ym, input logic [15:0] wd,
                                input logic [15:0] dh, input logic [15:0] eym,
                                input logic [15:0] ewd);
        int k;
        i_ctrl.setClock(16'h5959, 16'h2823, ym, wd);
        @(posedge clk);
        batteryPresent <= 1'b1;
        for (k = 0; k < 40 && secondPulse !== 1'b1; k++)
            @(negedge clk);
        check({15'h0000, secondPulse}, 16'h0001);
        @(posedge clk);
        batteryPresent <= 1'b0;
        expectReg(IDX_MIN_SEC, 16'h0000);
        expectReg(IDX_DAY_HOUR, dh);
        expectReg(IDX_YEAR_MONTH, eym);
        expectReg(IDX_WEEKDAY, ewd);
    endtask

    task automatic testCompensation();
        i_ctrl.setClock(16'h2045, 16'h0510, 16'h2401, 16'h0001);
        i_ctrl.wr(IDX_COMMAND, CMD_COMP30);
        expectReg(IDX_MIN_SEC, 16'h2045);
        @(posedge clk);
        batteryPresent <= 1'b1;
        repeat (2) @(posedge clk);
        i_ctrl.wr(IDX_COMMAND, CMD_COMP30);
        expectReg(IDX_MIN_SEC, 16'h2100);
        i_ctrl.wr(IDX_COMMAND, CMD_COMP30);
        batteryPresent <= 1'b0;
        expectReg(IDX_MIN_SEC, 16'h2100);
        expectReg(IDX_VIEW, 16'h1021);
    endtask

    task automatic testCompCarry();
        i_ctrl.setClock(16'h5945, 16'h3123, 16'h2412, 16'h0006);
        @(posedge clk);
        batteryPresent <= 1'b1;
        repeat (2) @(posedge clk);
        i_ctrl.wr(IDX_COMMAND, CMD_COMP30);
        batteryPresent <= 1'b0;
        expectReg(IDX_MIN_SEC, 16'h0000);
        expectReg(IDX_DAY_HOUR, 16'h0100);
        expectReg(IDX_YEAR_MONTH, 16'h2501);
        expectReg(IDX_WEEKDAY, 16'h0000);
    endtask

    task automatic testMode();
        @(posedge clk);
        modeSwitch <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check({15'h0000, masterMemoryEnable}, 16'h0001);
        @(posedge clk);
        modeSwitch <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check({15'h0000, masterMemoryEnable}, 16'h0000);
    endtask

    // ****************************************************
    // main sequence and watchdog
    // ****************************************************
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        testResetState();
        testSetAndHold();
        testRollover(16'h2302, 16'h0006, 16'h0100, 16'h2303, 16'h0000);
        testRollover(16'h2402, 16'h0003, 16'h2900, 16'h2402, 16'h0004);
        testCompensation();
        testCompCarry();
        testMode();
        conclude();
    end

    initial begin
        #(25 * 5000);
        n_fail++;
        conclude();
    end
endmodule
